//--- rtl/hufcp_params.svh
// constants for the host uart flow control port
// assumes a 125 MHz system clock and 8n1 framing
`ifndef HUFCP_PARAMS_SVH
`define HUFCP_PARAMS_SVH
`define HUFCP_CLK_HZ 125000000
`define HUFCP_DATA_BITS 8
`define HUFCP_FIFO_DEPTH 16
`define HUFCP_FIFO_AW 4
// sixteen ticks per bit; the tick accumulator adds 16 * rate per clock and wraps at clk
`define HUFCP_OVS 16
`define HUFCP_RATE_9600 9600
`define HUFCP_RATE_19200 19200
`define HUFCP_RATE_38400 38400
`define HUFCP_RATE_57600 57600
`define HUFCP_RATE_115200 115200
`define HUFCP_RATE_230400 230400
`define HUFCP_RATE_460800 460800
`define HUFCP_RATE_921600 921600
`define HUFCP_RATE_1M 1000000
`define HUFCP_RATE_CODE_MAX 4'h8
// rts deasserted (high) once this many slots are filled
`define HUFCP_RTS_STOP_LEVEL 5'h0c
`define HUFCP_RTS_GO_LEVEL 5'h08
// reset pin low time in ns, rounded up to cycles
`define HUFCP_T_RESET_NS 200
`define HUFCP_RESET_CYCLES ((`HUFCP_T_RESET_NS * 125 + 999) / 1000)
`endif

//--- rtl/hufcp_pkg.sv
// types shared by the host uart port files
// assumes the params header is included where constants are needed
package hufcp_pkg;
   typedef logic [7:0] hufcp_byte_t;
   typedef enum logic [1:0] {HUFCP_IDLE, HUFCP_START, HUFCP_DATA, HUFCP_STOP} hufcp_phase_e;
   // one byte stream beat
   typedef struct packed {
      logic valid;
      hufcp_byte_t data;
   } hufcp_beat_s;
endpackage

//--- rtl/hufcp_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module hufcp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [AW:0] level
);
   import hufcp_pkg::*;
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } hufcp_fst_s;
   hufcp_fst_s st_reg, st_next;
   logic [WIDTH-1:0] mem [DEPTH];
   logic wr, rd;
   // honest full and empty from the occupancy count
   assign in_ready = st_reg.cnt != (AW+1)'(DEPTH);
   assign out_valid = st_reg.cnt != '0;
   assign out_data = mem[st_reg.rp];
   assign level = st_reg.cnt;
   assign wr = in_valid && in_ready;
   assign rd = out_valid && out_ready;
   // pointer and count update
   always_comb begin
      st_next = st_reg;
      if (wr) st_next.wp = st_reg.wp + 1'b1;
      if (rd) st_next.rp = st_reg.rp + 1'b1;
      if (wr && !rd) st_next.cnt = st_reg.cnt + 1'b1;
      else if (rd && !wr) st_next.cnt = st_reg.cnt - 1'b1;
   end
   always_ff @(posedge clk) begin
      if (rst) st_reg <= '0;
      else st_reg <= st_next;
      if (wr) mem[st_reg.wp] <= in_data;
   end
endmodule
`default_nettype wire

//--- rtl/hufcp_top.sv
// host uart port of the wireless module: 8n1 transceiver with rts/cts
// assumes pins synchronous to CLOCK; the host keeps its own rate error in check
`timescale 1ns/1ps
`default_nettype none
`include "hufcp_params.svh"
module hufcp_top (
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic SUPPLY_OK,
   input wire logic EXTERNAL_RESET_N,
   input wire logic [3:0] RATE_SEL,
   input wire logic [3:0] RATE_LIMIT,
   input wire logic RXD,
   output logic TXD,
   output logic TXD_OE,
   input wire logic CTS_N,
   output logic RTS_N,
   output logic RTS_N_OE,
   input wire logic LINK_UP_REQUEST_IN_N,
   output logic LINK_UP_REQUEST_OUT_N,
   output logic LINK_UP_REQUEST_OUT_N_OE,
   input wire logic HANG_UP,
   input wire logic DATA_PHASE,
   output logic HANG_UP_REQ,
   input wire hufcp_pkg::hufcp_beat_s TX_IN,
   output logic TX_READY,
   output hufcp_pkg::hufcp_beat_s RX_OUT,
   input wire logic RX_READY,
   output logic LINK_UP_SEEN
);
   import hufcp_pkg::*;

   // accumulator step per clock: sixteen ticks per bit, one entry per rate code up to 8; codes above 8 share the 1 Mbps entry
   function automatic logic [26:0] step_of(input logic [3:0] code);
      int r;
      case (code)
         4'h0: r = `HUFCP_RATE_9600;
         4'h1: r = `HUFCP_RATE_19200;
         4'h2: r = `HUFCP_RATE_38400;
         4'h3: r = `HUFCP_RATE_57600;
         4'h4: r = `HUFCP_RATE_115200;
         4'h5: r = `HUFCP_RATE_230400;
         4'h6: r = `HUFCP_RATE_460800;
         4'h7: r = `HUFCP_RATE_921600;
         default: r = `HUFCP_RATE_1M;
      endcase
      // exact on average; each tick lands within one clock of its ideal time,
      // so even 1 Mbps stays well inside one percent, unlike an integer divisor
      step_of = 27'(r * `HUFCP_OVS);
   endfunction

   typedef struct packed {
      logic [4:0] rst_cnt;
      logic in_reset;
      logic [3:0] rate;
      logic [26:0] phase_acc;
      hufcp_phase_e tx_ph;
      logic [3:0] tx_sub;
      logic [2:0] tx_bit;
      hufcp_byte_t tx_sh;
      logic txd;
      hufcp_phase_e rx_ph;
      logic [3:0] rx_sub;
      logic [2:0] rx_bit;
      hufcp_byte_t rx_sh;
      logic rx_push;
      logic rts_n;
      logic hang;
      logic hang_q;
      logic link_up;
   } hufcp_st_s;
   hufcp_st_s st_reg, st_next;

   logic tick, rst_any, f_in_ready, f_out_valid, rx_fifo_ready;
   logic [7:0] f_out_data;
   logic [4:0] f_level;
   logic [3:0] eff_rate;
   logic [27:0] acc_sum;

   assign rst_any = SYS_RST || st_reg.in_reset;
   // firmware cap: requested rate clamped to the limit code
   assign eff_rate = (RATE_SEL > RATE_LIMIT) ? RATE_LIMIT : RATE_SEL;
   // one-cycle tick when the accumulator passes the clock rate
   assign acc_sum = {1'b0, st_reg.phase_acc} + 28'(step_of(st_reg.rate));
   assign tick = acc_sum >= 28'(`HUFCP_CLK_HZ);

   // received bytes buffered toward the user side
   hufcp_fifo #(.WIDTH(8), .DEPTH(`HUFCP_FIFO_DEPTH), .AW(`HUFCP_FIFO_AW)) u_rx_fifo (
      .clk(CLOCK),
      .rst(rst_any),
      .in_valid(st_reg.rx_push),
      .in_ready(f_in_ready),
      .in_data(st_reg.rx_sh),
      .out_valid(f_out_valid),
      .out_ready(rx_fifo_ready),
      .out_data(f_out_data),
      .level(f_level)
   );
   // pop only the byte the user sees, so a held ready cannot drain unseen bytes
   assign rx_fifo_ready = RX_READY && RX_OUT.valid;

   // next-state logic for reset stretch, baud, tx, rx and flow control
   always_comb begin
      st_next = st_reg;
      st_next.rx_push = 1'b0;
      // supply monitor and pin reset hold the port in reset
      if (!SUPPLY_OK) begin
         st_next.in_reset = 1'b1;
         st_next.rst_cnt = '0;
      end else if (!EXTERNAL_RESET_N) begin
         if (st_reg.rst_cnt != 5'(`HUFCP_RESET_CYCLES - 1)) begin
            st_next.rst_cnt = st_reg.rst_cnt + 1'b1;
         end else begin
            st_next.in_reset = 1'b1;
         end
      end else begin
         st_next.rst_cnt = '0;
         st_next.in_reset = 1'b0;
      end
      // sixteen-times oversampling enable; rate picked up only between frames
      if (tick) st_next.phase_acc = 27'(acc_sum - 28'(`HUFCP_CLK_HZ));
      else st_next.phase_acc = acc_sum[26:0];
      if (st_reg.tx_ph == HUFCP_IDLE && st_reg.rx_ph == HUFCP_IDLE) st_next.rate = eff_rate;
      // transmitter: start only with cts asserted low
      if (tick) begin
         case (st_reg.tx_ph)
            HUFCP_IDLE: begin
               st_next.txd = 1'b1;
               if (TX_IN.valid && !CTS_N) begin
                  st_next.tx_sh = TX_IN.data;
                  st_next.tx_ph = HUFCP_START;
                  st_next.txd = 1'b0;
                  st_next.tx_sub = '0;
               end
            end
            HUFCP_START, HUFCP_DATA: begin
               st_next.tx_sub = st_reg.tx_sub + 1'b1;
               if (st_reg.tx_sub == 4'hf) begin
                  if (st_reg.tx_ph == HUFCP_START) st_next.tx_bit = '0;
                  else st_next.tx_bit = st_reg.tx_bit + 1'b1;
                  if (st_reg.tx_ph == HUFCP_DATA && st_reg.tx_bit == 3'h7) begin
                     st_next.tx_ph = HUFCP_STOP;
                     st_next.txd = 1'b1;
                  end else begin
                     st_next.tx_ph = HUFCP_DATA;
                     st_next.txd = st_reg.tx_sh[0];
                     st_next.tx_sh = {1'b0, st_reg.tx_sh[7:1]};
                  end
               end
            end
            default: begin
               st_next.tx_sub = st_reg.tx_sub + 1'b1;
               if (st_reg.tx_sub == 4'hf) st_next.tx_ph = HUFCP_IDLE;
            end
         endcase
      end
      // receiver: mid-bit sampling, stop bit must be high
      if (tick) begin
         case (st_reg.rx_ph)
            HUFCP_IDLE: begin
               if (!RXD) begin
                  st_next.rx_ph = HUFCP_START;
                  st_next.rx_sub = '0;
               end
            end
            HUFCP_START: begin
               st_next.rx_sub = st_reg.rx_sub + 1'b1;
               if (st_reg.rx_sub == 4'h7) begin
                  st_next.rx_sub = '0;
                  st_next.rx_bit = '0;
                  // a glitch that is high at mid-bit is not a start
                  st_next.rx_ph = RXD ? HUFCP_IDLE : HUFCP_DATA;
               end
            end
            HUFCP_DATA: begin
               st_next.rx_sub = st_reg.rx_sub + 1'b1;
               if (st_reg.rx_sub == 4'hf) begin
                  st_next.rx_sh = {RXD, st_reg.rx_sh[7:1]};
                  st_next.rx_bit = st_reg.rx_bit + 1'b1;
                  if (st_reg.rx_bit == 3'h7) st_next.rx_ph = HUFCP_STOP;
               end
            end
            default: begin
               st_next.rx_sub = st_reg.rx_sub + 1'b1;
               if (st_reg.rx_sub == 4'hf) begin
                  st_next.rx_ph = HUFCP_IDLE;
                  // framing error (low stop) drops the byte; full fifo also drops
                  st_next.rx_push = RXD && f_in_ready;
               end
            end
         endcase
      end
      // rts hysteresis leaves room for the host's in-flight bytes
      if (f_level >= `HUFCP_RTS_STOP_LEVEL) st_next.rts_n = 1'b1;
      else if (f_level <= `HUFCP_RTS_GO_LEVEL) st_next.rts_n = 1'b0;
      // hang-up: a rising level during data transfer raises a one-cycle request
      st_next.hang_q = HANG_UP;
      st_next.hang = HANG_UP && !st_reg.hang_q && DATA_PHASE;
      // optional link-up request; open input reads high, i.e. no request
      st_next.link_up = !LINK_UP_REQUEST_IN_N;
   end

   // reset values; the external reset path is self-clearing through rst_cnt
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         st_reg <= '0;
         st_reg.txd <= 1'b1;
         st_reg.rts_n <= 1'b1;
         st_reg.hang_q <= 1'b1;
      end else if (st_reg.in_reset) begin
         st_reg <= '0;
         st_reg.in_reset <= st_next.in_reset;
         st_reg.rst_cnt <= st_next.rst_cnt;
         st_reg.txd <= 1'b1;
         st_reg.rts_n <= 1'b1;
         st_reg.hang_q <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // output flops; enables low keep the pins undriven during reset
   always_ff @(posedge CLOCK) begin
      if (rst_any) begin
         TXD <= 1'b1;
         TXD_OE <= 1'b0;
         RTS_N <= 1'b1;
         RTS_N_OE <= 1'b0;
         LINK_UP_REQUEST_OUT_N <= 1'b1;
         LINK_UP_REQUEST_OUT_N_OE <= 1'b0;
         HANG_UP_REQ <= 1'b0;
         TX_READY <= 1'b0;
         RX_OUT <= '0;
         LINK_UP_SEEN <= 1'b0;
      end else begin
         TXD <= st_next.txd;
         TXD_OE <= 1'b1;
         RTS_N <= st_next.rts_n;
         RTS_N_OE <= 1'b1;
         LINK_UP_REQUEST_OUT_N <= 1'b0;
         LINK_UP_REQUEST_OUT_N_OE <= 1'b1;
         HANG_UP_REQ <= st_next.hang;
         TX_READY <= tick && st_reg.tx_ph == HUFCP_IDLE && !CTS_N && TX_IN.valid;
         RX_OUT.valid <= f_out_valid && !rx_fifo_ready;
         RX_OUT.data <= f_out_data;
         LINK_UP_SEEN <= st_next.link_up;
      end
   end
endmodule
`default_nettype wire

//--- verification/hufcp_props.sv
// concurrent checks on the host uart port pins and stream side
// assumes the bench holds tx_in and cts steady until the take pulse
`timescale 1ns/1ps
`default_nettype none
module hufcp_props (
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic SUPPLY_OK,
   input wire logic TXD,
   input wire logic TXD_OE,
   input wire logic CTS_N,
   input wire logic RTS_N,
   input wire logic LINK_UP_REQUEST_IN_N,
   input wire logic HANG_UP,
   input wire logic DATA_PHASE,
   input wire logic HANG_UP_REQ,
   input wire hufcp_pkg::hufcp_beat_s TX_IN,
   input wire logic TX_READY,
   input wire hufcp_pkg::hufcp_beat_s RX_OUT,
   input wire logic RX_READY,
   input wire logic LINK_UP_SEEN
);
   import hufcp_pkg::*;
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (SYS_RST);
   // an undriven port must still look idle to the host
   AST_IDLE_UNDRIVEN: assert property (!TXD_OE |-> TXD && RTS_N)
      else $error("txd or rts low while port undriven");
   AST_TX_GATE: assert property (TX_READY |-> !$past(CTS_N) && $past(TX_IN.valid))
      else $error("byte taken without clear to send");
   // start bit holds txd low for at least eight cycles after the take
   AST_TX_START: assert property (TX_READY |=> !TXD [*8])
      else $error("start bit missing after take");
   AST_TX_PULSE: assert property (TX_READY |=> !TX_READY)
      else $error("take pulse longer than one cycle");
   AST_HANG_RISE: assert property ($rose(HANG_UP) && DATA_PHASE |-> ##[1:2] HANG_UP_REQ)
      else $error("hang up not reported");
   AST_HANG_CAUSE: assert property (HANG_UP_REQ |-> $past(HANG_UP) && !$past(HANG_UP, 2)
      && $past(DATA_PHASE) && !$past(HANG_UP_REQ))
      else $error("hang up report without cause");
   AST_LINK_MIRROR: assert property (LINK_UP_SEEN == !$past(LINK_UP_REQUEST_IN_N))
      else $error("link up flag does not follow its input");
   AST_RX_HOLD: assert property (RX_OUT.valid && !RX_READY |=> RX_OUT.valid && $stable(RX_OUT.data))
      else $error("received byte lost before pop");
   // reset is entered one edge after the low level, the pins follow one edge later
   AST_SUPPLY_LOW: assert property (!SUPPLY_OK |-> ##2 !TXD_OE)
      else $error("port driven while supply low");
endmodule
bind hufcp_top hufcp_props i_hufcp_props (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
   .SUPPLY_OK(SUPPLY_OK), .TXD(TXD), .TXD_OE(TXD_OE), .CTS_N(CTS_N), .RTS_N(RTS_N),
   .LINK_UP_REQUEST_IN_N(LINK_UP_REQUEST_IN_N), .HANG_UP(HANG_UP), .DATA_PHASE(DATA_PHASE),
   .HANG_UP_REQ(HANG_UP_REQ), .TX_IN(TX_IN), .TX_READY(TX_READY), .RX_OUT(RX_OUT),
   .RX_READY(RX_READY), .LINK_UP_SEEN(LINK_UP_SEEN));
`default_nettype wire

//--- verification/hufcp_host.sv
// host side uart model: drives the device receive line, samples its transmit line
// assumes the bench sets bit_cyc to one bit time in clock cycles
`timescale 1ns/1ps
`default_nettype none
module hufcp_host (
   input wire logic clk,
   input wire logic txd,
   output logic rxd
);
   int bit_cyc = 125;
   initial rxd = 1'b1; // line idles high
   // exact nominal bit time, so the whole error budget is the device's
   task automatic send(input logic [7:0] b);
      logic [9:0] frame;
      frame = {1'b1, b, 1'b0}; // low start, lsb first, one high stop
      for (int i = 0; i < 10; i++) begin
         @(negedge clk);
         rxd <= frame[i];
         repeat (bit_cyc - 1) @(negedge clk);
      end
   endtask
   // samples at mid bit; a wrong bit time shifts the samples off their bits
   task automatic recv(output logic [7:0] b, output logic ok);
      int n;
      n = 0;
      ok = 1'b0;
      b = 8'h00;
      // looks at the line on falling edges, away from the edge that launches it
      while (txd !== 1'b0 && n < 20000) begin
         @(negedge clk);
         n++;
      end
      repeat (bit_cyc / 2) @(negedge clk);
      ok = (txd === 1'b0) && (n < 20000);
      for (int i = 0; i < 8; i++) begin
         repeat (bit_cyc) @(negedge clk);
         b[i] = txd; // lsb first
      end
      repeat (bit_cyc) @(negedge clk);
      ok = ok && (txd === 1'b1); // single stop bit
   endtask
endmodule
`default_nettype wire

//--- verification/testbench.sv
// self-checking bench for the host uart port with a host model on the serial lines
// assumes rate code 8, where one bit lasts 125 clock cycles on average
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import hufcp_pkg::*;
   logic clk = 1'b0, sys_rst = 1'b1, supply_ok = 1'b1, ext_rst_n = 1'b1;
   logic [3:0] rate_sel = 4'h8, rate_limit = 4'h8;
   logic rxd, txd, txd_oe, cts_n = 1'b0, rts_n, rts_n_oe, lin_n = 1'b1, lout_n, lout_oe;
   logic hang_up = 1'b0, data_phase = 1'b0, hang_req, tx_ready, rx_ready = 1'b0, link_seen;
   hufcp_beat_s tx_in = '0, rx_out;
   int n_mismatch = 0, cmp_count = 0, hang_cnt = 0;
   always #4 clk = ~clk;
   always @(posedge clk) if (hang_req === 1'b1) hang_cnt++;
   hufcp_top i_hufcp_top (.CLOCK(clk), .SYS_RST(sys_rst), .SUPPLY_OK(supply_ok),
      .EXTERNAL_RESET_N(ext_rst_n), .RATE_SEL(rate_sel), .RATE_LIMIT(rate_limit), .RXD(rxd),
      .TXD(txd), .TXD_OE(txd_oe), .CTS_N(cts_n), .RTS_N(rts_n), .RTS_N_OE(rts_n_oe),
      .LINK_UP_REQUEST_IN_N(lin_n), .LINK_UP_REQUEST_OUT_N(lout_n),
      .LINK_UP_REQUEST_OUT_N_OE(lout_oe), .HANG_UP(hang_up), .DATA_PHASE(data_phase),
      .HANG_UP_REQ(hang_req), .TX_IN(tx_in), .TX_READY(tx_ready), .RX_OUT(rx_out),
      .RX_READY(rx_ready), .LINK_UP_SEEN(link_seen));
   hufcp_host i_hufcp_host (.clk(clk), .txd(txd), .rxd(rxd));
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // holds the beat until the take pulse, sampled mid cycle to avoid edge races
   task automatic push(input logic [7:0] b);
      int n;
      n = 0;
      @(negedge clk);
      tx_in <= '{1'b1, b};
      while (tx_ready !== 1'b1 && n < 5000) begin
         @(negedge clk);
         n++;
      end
      tx_in.valid <= 1'b0;
   endtask
   task automatic tx_frame(input logic [7:0] b, input string what);
      logic [7:0] got;
      logic ok;
      fork
         push(b);
         i_hufcp_host.recv(got, ok);
      join
      check(what, b, got);
      check("framing", 8'h01, {7'h00, ok});
   endtask
   task automatic t_reset();
      repeat (10) @(negedge clk);
      check("oe in reset", 8'h00, {6'h00, txd_oe, rts_n_oe});
      check("rts in reset", 8'h01, {7'h00, rts_n});
      sys_rst <= 1'b0;
      repeat (3) @(negedge clk);
      check("idle txd", 8'h03, {6'h00, txd, txd_oe});
      check("link out", 8'h01, {6'h00, lout_n, lout_oe});
      $display("t_reset done");
   endtask
   // back to back frames with boundary bit patterns
   task automatic t_tx();
      tx_frame(8'ha5, "tx a5");
      tx_frame(8'h01, "tx 01");
      tx_frame(8'h80, "tx 80");
      $display("t_tx done");
   endtask
   task automatic t_cts();
      logic held;
      held = 1'b1;
      cts_n <= 1'b1;
      fork
         tx_frame(8'h3c, "cts frame");
         begin
            repeat (2000) begin
               @(negedge clk);
               held &= (txd === 1'b1) && (tx_ready !== 1'b1);
            end
            check("txd held", 8'h01, {7'h00, held});
            cts_n <= 1'b0;
         end
      join
      $display("t_cts done");
   endtask
   // code 6 is 460800: about 271.3 cycles a bit; 271 keeps the host within 0.1 percent
   task automatic t_limit();
      rate_limit <= 4'h6;
      i_hufcp_host.bit_cyc = 271;
      repeat (4) @(negedge clk);
      tx_frame(8'h5a, "limited rate");
      // codes above 8 fall back to 1 Mbps, 125 cycles a bit
      rate_sel <= 4'h9;
      rate_limit <= 4'hf;
      i_hufcp_host.bit_cyc = 125;
      repeat (4) @(negedge clk);
      tx_frame(8'hc3, "rate code 9");
      rate_sel <= 4'h8;
      rate_limit <= 4'h8;
      repeat (4) @(negedge clk);
      $display("t_limit done");
   endtask
   // host ignores rts on purpose to overrun the sixteen word buffer
   task automatic t_rx();
      int n;
      for (int i = 0; i < 17; i++) begin
         i_hufcp_host.send(8'h40 + i[7:0]);
         repeat (40) @(negedge clk);
         if (i == 10) check("rts at 11", 8'h00, {7'h00, rts_n});
         if (i == 11) check("rts at 12", 8'h01, {7'h00, rts_n});
      end
      for (int i = 0; i < 16; i++) begin
         n = 0;
         while (rx_out.valid !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
         end
         check("rx byte", 8'h40 + i[7:0], rx_out.data);
         rx_ready <= 1'b1;
         @(negedge clk);
         rx_ready <= 1'b0;
         repeat (2) @(negedge clk);
      end
      check("overrun dropped", 8'h00, {7'h00, rx_out.valid});
      check("rts drained", 8'h00, {7'h00, rts_n});
      $display("t_rx done");
   endtask
   task automatic t_side();
      hang_up <= 1'b1;
      repeat (5) @(negedge clk);
      hang_up <= 1'b0;
      data_phase <= 1'b1;
      repeat (2) @(negedge clk);
      hang_up <= 1'b1;
      repeat (5) @(negedge clk);
      check("hang up count", 8'h01, 8'(hang_cnt));
      lin_n <= 1'b0;
      repeat (4) @(negedge clk);
      check("link seen", 8'h01, {7'h00, link_seen});
      lin_n <= 1'b1;
      // a pulse well under the minimum low time must not reset the port
      ext_rst_n <= 1'b0;
      repeat (10) @(negedge clk);
      ext_rst_n <= 1'b1;
      check("short pin pulse", 8'h01, {7'h00, txd_oe});
      repeat (4) @(negedge clk);
      ext_rst_n <= 1'b0;
      repeat (40) @(negedge clk);
      check("pin reset", 8'h01, {6'h00, txd_oe, rts_n});
      ext_rst_n <= 1'b1;
      repeat (40) @(negedge clk);
      supply_ok <= 1'b0;
      repeat (3) @(negedge clk);
      check("brownout", 8'h01, {6'h00, txd_oe, rts_n});
      supply_ok <= 1'b1;
      repeat (40) @(negedge clk);
      check("after resets", 8'h01, {7'h00, txd_oe});
      $display("t_side done");
   endtask
   initial begin
      repeat (80000) @(posedge clk);
      n_mismatch++;
      end_of_test();
   end
   initial begin
      t_reset();
      t_tx();
      t_cts();
      t_limit();
      t_rx();
      t_side();
      end_of_test();
   end
endmodule
`default_nettype wire
